// ==== src/dcw_params.svh ====
// Constants for the synthesizer control word decoder.
// Assumes 16-bit serial words, MSB first, two address bits on top.
`ifndef DCW_PARAMS_SVH
`define DCW_PARAMS_SVH
`define DCW_WORD_BITS 16
`define DCW_HALF_BITS 14
`define DCW_PHASE_BITS 12
`define DCW_ADDR_CTRL 2'h0
`define DCW_ADDR_FREQ_A 2'h1
`define DCW_ADDR_FREQ_B 2'h2
`define DCW_ADDR_PHASE 2'h3
`define DCW_BIT_FULL_WORD 13
`define DCW_BIT_HIGH_SEL 12
`define DCW_BIT_FREQ_SEL 11
`define DCW_BIT_PHASE_SEL 10
`define DCW_BIT_SRC_SEL 9
`define DCW_BIT_RESET 8
`define DCW_BIT_PHASE_REG 13
`define DCW_CTRL_RESET 14'h0000
`define DCW_FREQ_RESET 28'h000_0000
`define DCW_PHASE_RESET 12'h000
`define DCW_LAST_BIT 4'hf
`endif

// ==== src/dcw_pkg.sv ====
// Types shared by the synthesizer control word decoder.
// Assumes dcw_params.svh is on the include path.
package dcw_pkg;
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic frame_sync_n;
  } dcw_serial_type;
  typedef struct packed {
    logic freq_select_pin;
    logic phase_select_pin;
    logic reset_pin;
    logic power_down_pin;
  } dcw_pins_type;
  typedef struct packed {
    logic full_word_two_write_mode;
    logic half_word_high_select;
    logic freq_reg_select_bit;
    logic phase_reg_select_bit;
    logic control_source_select;
    logic reset_bit;
    logic [7:0] lower_bits;
  } dcw_ctrl_type;
  typedef enum logic [1:0] {
    DCW_IDLE = 2'b00,
    DCW_SHIFT = 2'b01,
    DCW_DONE = 2'b11
  } dcw_state_type;
endpackage

// ==== src/dcw_control_word.sv ====
// Serial control word receiver and decoder of a synthesizer.
// Assumes serial pins and control pins are asynchronous to sys_clk_in,
// which must run well above four times the serial clock rate.
`timescale 1ns/1ps
`include "dcw_params.svh"

module dcw_control_word (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire dcw_pkg::dcw_serial_type serial_in,
  input wire dcw_pkg::dcw_pins_type pins_in,
  output logic [27:0] freq_word_out,
  output logic [11:0] phase_offset_out,
  output logic core_reset_out,
  output logic dac_power_down_out,
  output dcw_pkg::dcw_ctrl_type control_word_out
);
  import dcw_pkg::*;

  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic sclk_prev_reg;
  logic sclk_s;
  logic sdata_s;
  logic frame_sync_n_n_s;
  logic sclk_fall;
  dcw_state_type state_reg;
  logic [3:0] count_reg;
  logic [15:0] shift_reg;
  logic [15:0] word_reg;
  dcw_ctrl_type ctrl_reg;
  logic [27:0] freq_word_a;
  logic [27:0] freq_word_b;
  logic [11:0] phase_offset_a;
  logic [11:0] phase_offset_b;
  logic [13:0] low_hold_reg;
  logic low_pending_reg;
  logic [1:0] addr;
  logic [13:0] data;
  logic is_freq;
  logic pin_mode;
  logic eff_freq_reg_select_bit;
  logic eff_psel;
  logic eff_reset;
  logic eff_pd;

  // Two flops on every pin; the first stage feeds only the second
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1_reg <= 7'h7f;
      sync2_reg <= 7'h7f;
    end else begin
      sync1_reg <= {serial_in, pins_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign sclk_s = sync2_reg[6];
  assign sdata_s = sync2_reg[5];
  assign frame_sync_n_n_s = sync2_reg[4];

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_s;
    end
  end

  assign sclk_fall = sclk_prev_reg & ~sclk_s;

  // Frame sync low admits bits; it may stay low over many words
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= DCW_IDLE;
      count_reg <= 4'h0;
      shift_reg <= 16'h0000;
      word_reg <= 16'h0000;
    end else if (frame_sync_n_n_s) begin
      state_reg <= DCW_IDLE;
      count_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        DCW_IDLE, DCW_DONE: begin
          state_reg <= DCW_SHIFT;
          if (sclk_fall) begin
            shift_reg <= {shift_reg[14:0], sdata_s};
            count_reg <= 4'h1;
          end else begin
            count_reg <= 4'h0;
          end
        end
        DCW_SHIFT: begin
          if (sclk_fall) begin
            shift_reg <= {shift_reg[14:0], sdata_s};
            count_reg <= count_reg + 4'h1;
            if (count_reg == `DCW_LAST_BIT) begin
              state_reg <= DCW_DONE;
              word_reg <= {shift_reg[14:0], sdata_s};
            end
          end
        end
      endcase
    end
  end

  // A word sits in word_reg during the single DONE cycle
  assign addr = word_reg[15:14];
  assign data = word_reg[13:0];
  assign is_freq = (state_reg == DCW_DONE) &&
                   (addr == `DCW_ADDR_FREQ_A || addr == `DCW_ADDR_FREQ_B);

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_reg <= `DCW_CTRL_RESET;
    end else if (state_reg == DCW_DONE && addr == `DCW_ADDR_CTRL) begin
      ctrl_reg <= data;
    end
  end

  // Full-word pairing; a control write abandons a half-finished pair
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      low_pending_reg <= 1'b0;
      low_hold_reg <= 14'h0000;
    end else if (state_reg == DCW_DONE && addr == `DCW_ADDR_CTRL) begin
      low_pending_reg <= 1'b0;
    end else if (is_freq && ctrl_reg.full_word_two_write_mode) begin
      low_pending_reg <= ~low_pending_reg;
      if (!low_pending_reg) begin
        low_hold_reg <= data;
      end
    end
  end

  // Destination of the second half follows its own address bits;
  // pairs that mix addresses are the host's fault and not checked
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      freq_word_a <= `DCW_FREQ_RESET;
      freq_word_b <= `DCW_FREQ_RESET;
    end else if (is_freq) begin
      if (ctrl_reg.full_word_two_write_mode) begin
        if (low_pending_reg) begin
          if (addr == `DCW_ADDR_FREQ_A) begin
            freq_word_a <= {data, low_hold_reg};
          end else begin
            freq_word_b <= {data, low_hold_reg};
          end
        end
      end else if (ctrl_reg.half_word_high_select) begin
        if (addr == `DCW_ADDR_FREQ_A) begin
          freq_word_a[27:14] <= data;
        end else begin
          freq_word_b[27:14] <= data;
        end
      end else begin
        if (addr == `DCW_ADDR_FREQ_A) begin
          freq_word_a[13:0] <= data;
        end else begin
          freq_word_b[13:0] <= data;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase_offset_a <= `DCW_PHASE_RESET;
      phase_offset_b <= `DCW_PHASE_RESET;
    end else if (state_reg == DCW_DONE && addr == `DCW_ADDR_PHASE) begin
      if (data[`DCW_BIT_PHASE_REG]) begin
        phase_offset_b <= data[11:0];
      end else begin
        phase_offset_a <= data[11:0];
      end
    end
  end

  // Pin mode hides the bits; power-down has no bit in this word
  assign pin_mode = ctrl_reg.control_source_select;
  assign eff_freq_reg_select_bit = pin_mode ? sync2_reg[3]
                             : ctrl_reg.freq_reg_select_bit;
  assign eff_psel = pin_mode ? sync2_reg[2]
                             : ctrl_reg.phase_reg_select_bit;
  assign eff_reset = pin_mode ? sync2_reg[1] : ctrl_reg.reset_bit;
  assign eff_pd = pin_mode & sync2_reg[0];

  // One register stage samples the chosen controls on the master clock
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      freq_word_out <= `DCW_FREQ_RESET;
      phase_offset_out <= `DCW_PHASE_RESET;
      core_reset_out <= 1'b0;
      dac_power_down_out <= 1'b0;
      control_word_out <= `DCW_CTRL_RESET;
    end else begin
      freq_word_out <= eff_freq_reg_select_bit ? freq_word_b : freq_word_a;
      phase_offset_out <= eff_psel ? phase_offset_b
                                   : phase_offset_a;
      core_reset_out <= eff_reset;
      dac_power_down_out <= eff_pd;
      control_word_out <= ctrl_reg;
    end
  end

endmodule

// ==== sim/dcw_host_model.sv ====
// Host model: writes 16-bit words over the three-wire serial port.
// Assumes the bench calls its tasks; pins change on falling sys_clk.
`timescale 1ns/1ps
module dcw_host_model (
  input wire logic sys_clk_in,
  output dcw_pkg::dcw_serial_type serial_out
);
  import dcw_pkg::*;
  initial serial_out = 3'h5;
  task automatic gap(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  // Three cycles per sclk phase keeps the receiver's sync chain happy
  task automatic send_word(input logic [15:0] w);
    serial_out.frame_sync_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_out.sdata = w[i];
      gap(3);
      serial_out.sclk = 1'b0;
      gap(3);
      serial_out.sclk = 1'b1;
    end
    gap(3);
    serial_out.frame_sync_n = 1'b1;
    // Released line shows the inverse, never a stale bit
    serial_out.sdata = ~w[0];
  endtask
  // Same address in both words, low half first; caller alternates regs
  task automatic send_pair(input logic [1:0] a, input logic [27:0] v);
    send_word({a, v[13:0]});
    // Idle a moment so no pin is set twice in one time step
    gap(3);
    send_word({a, v[27:14]});
  endtask
endmodule

// ==== sim/dcw_checker_assertions.sv ====
// Port checker of the control word decoder.
// Assumes binding to dcw_control_word; single clock domain.
`timescale 1ns/1ps
module dcw_checker (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire dcw_pkg::dcw_serial_type serial_in,
  input wire dcw_pkg::dcw_pins_type pins_in,
  input wire logic [27:0] freq_word_out,
  input wire logic [11:0] phase_offset_out,
  input wire logic core_reset_out,
  input wire logic dac_power_down_out,
  input wire dcw_pkg::dcw_ctrl_type control_word_out
);
  import dcw_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire src = control_word_out.control_source_select;
  wire rbit = control_word_out.reset_bit;
  wire idle = serial_in.frame_sync_n;
  chk_pd_bit_mode: assert property (!src [*3] |-> !dac_power_down_out)
    else $error("power-down set in bit mode");
  chk_pd_pin: assert property (src [*5] |->
    dac_power_down_out == $past(pins_in.power_down_pin, 3))
    else $error("power-down does not follow pin");
  chk_reset_pin: assert property (src [*5] |->
    core_reset_out == $past(pins_in.reset_pin, 3))
    else $error("core reset does not follow pin");
  chk_reset_bit: assert property ((!src && $stable(rbit)) [*3] |->
    core_reset_out == rbit)
    else $error("core reset does not follow bit");
  chk_freq_quiet: assert property ((idle && !src) [*8] |->
    $stable(freq_word_out))
    else $error("frequency changed with no word");
  chk_phase_quiet: assert property ((idle && !src) [*8] |->
    $stable(phase_offset_out))
    else $error("phase changed with no word");
  chk_ctrl_quiet: assert property (idle [*8] |->
    $stable(control_word_out))
    else $error("control bits changed with no word");
  chk_half_only: assert property (!src &&
    !control_word_out.full_word_two_write_mode &&
    control_word_out == $past(control_word_out, 3) &&
    $changed(freq_word_out[13:0]) |-> $stable(freq_word_out[27:14]))
    else $error("both halves changed in half-word mode");
  cov_full: cover property (control_word_out.full_word_two_write_mode &&
    $changed(freq_word_out));
  cov_pd: cover property (dac_power_down_out);
  cov_rst: cover property (!src && core_reset_out);
endmodule
bind dcw_control_word dcw_checker dcw_checker_inst (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
  .serial_in(serial_in), .pins_in(pins_in),
  .freq_word_out(freq_word_out), .phase_offset_out(phase_offset_out),
  .core_reset_out(core_reset_out),
  .dac_power_down_out(dac_power_down_out),
  .control_word_out(control_word_out));

// ==== sim/dcw_control_word_bench.sv ====
// Self-checking bench of the control word decoder.
// Assumes host model and bound checker are compiled before it.
`timescale 1ns/1ps
module dcw_control_word_bench;
  import dcw_pkg::*;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  dcw_serial_type serial;
  dcw_pins_type pins = 4'h0;
  logic [27:0] freq;
  logic [11:0] phase;
  logic core_rst;
  logic pd;
  dcw_ctrl_type ctrl;
  int err_count = 0;
  int check_count = 0;
  `define CHK(nm, exp, got) begin check_count++; \
    if ((got) !== (exp)) begin err_count++; \
    $display("wrong value %s exp %h got %h", nm, exp, got); end end
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  dcw_host_model dcw_host_model_inst (.sys_clk_in(sys_clk_in),
    .serial_out(serial));
  dcw_control_word dcw_control_word_inst (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .serial_in(serial), .pins_in(pins),
    .freq_word_out(freq), .phase_offset_out(phase),
    .core_reset_out(core_rst), .dac_power_down_out(pd),
    .control_word_out(ctrl));
  // Outputs settle about five cycles after the last sclk fall, before the frame ends; eight is safe
  task automatic wr(input logic [15:0] w);
    dcw_host_model_inst.send_word(w);
    repeat (8) @(negedge sys_clk_in);
  endtask
  task automatic t_half;
    `CHK("freq", 28'h000_0000, freq)
    wr(16'h0000);
    wr(16'h5234);
    `CHK("low half", 28'h000_1234, freq)
    wr(16'h1000);
    wr(16'h4abc);
    `CHK("high half", 28'h2af_1234, freq)
  endtask
  task automatic t_full;
    wr(16'h3800);
    `CHK("freq b", 28'h000_0000, freq)
    wr(16'h8155);
    `CHK("after low", 28'h000_0000, freq)
    wr(16'haaaa);
    `CHK("full", 28'haaa_8155, freq)
    dcw_host_model_inst.send_pair(2'h1, 28'h123_4567);
    repeat (8) @(negedge sys_clk_in);
    `CHK("b kept", 28'haaa_8155, freq)
    wr(16'h2000);
    `CHK("freq a", 28'h123_4567, freq)
  endtask
  task automatic t_phase;
    wr(16'he5a5);
    `CHK("phase a", 12'h000, phase)
    wr(16'h0400);
    `CHK("phase", 12'h5a5, phase)
    `CHK("ctrl", 14'h0400, ctrl)
  endtask
  task automatic t_pins;
    wr(16'h0f00);
    `CHK("pin reset", 1'b0, core_rst)
    `CHK("pin freq", 28'h123_4567, freq)
    `CHK("pin phase", 12'h000, phase)
    pins = 4'hf;
    repeat (5) @(negedge sys_clk_in);
    `CHK("pin freq b", 28'haaa_8155, freq)
    `CHK("pin phase b", 12'h5a5, phase)
    `CHK("pin reset on", 1'b1, core_rst)
    `CHK("pin pd", 1'b1, pd)
    pins = 4'h0;
    wr(16'h0100);
    `CHK("bit reset", 1'b1, core_rst)
    `CHK("bit pd", 1'b0, pd)
    wr(16'h0000);
    `CHK("reset off", 1'b0, core_rst)
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Fifteen words of some 110 cycles each; ample margin
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    err_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    t_half();
    t_full();
    t_phase();
    t_pins();
    stop_test();
  end
endmodule
